//--- rtl/adc_mode_control.sv
// ADC conversion mode control register and conversion sequencer.
`include "adc_mode_defines.svh"
module adc_mode_control #(
  parameter int CONV_CYCLES = 16
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic [7:0]              sfr_wdata,
  input  wire logic                    sfr_wr,
  input  wire logic                    bit_wr,
  input  wire logic [2:0]              bit_sel,
  input  wire logic                    bit_val,
  output logic [7:0]                   sfr_rdata,
  input  wire logic                    irq_vector_ack,
  input  wire logic                    timer_two_trigger_enable,
  input  wire logic                    pin_trigger_enable,
  input  wire logic                    timer_two_overflow,
  input  wire logic                    ext_conv_start_pin_n,
  input  wire logic                    block_last_conv,
  input  wire logic [3:0]              block_chan,
  input  wire logic                    core_ale,
  output logic                         ale_out,
  output logic                         conv_start,
  output logic [3:0]                   conv_chan,
  output adc_mode_pkg::chan_src_t      conv_src,
  output logic                         conv_busy,
  output logic                         conv_done_flag
);
  import adc_mode_pkg::*;

  if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin : g_bad_cycles
    $error("CONV_CYCLES out of range");
  end

  // ************************************************************
  // Register and start sources
  // ************************************************************
  logic [7:0]  reg_q;
  logic [7:0]  reg_d;
  logic [7:0]  cnt_q;
  conv_state_t state_q;
  logic        sel_hit;
  logic        conv_end;
  logic        block_end;
  logic        hw_start;
  logic        sw_start;
  logic        any_start;
  logic        next_start;
  logic        use_block;
  start_trig_if trig ();

  assign trig.pin_enable = pin_trigger_enable;
  start_pin_filter u_pin (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .ext_conv_start_pin_n (ext_conv_start_pin_n),
    .trig                 (trig)
  );

  assign sel_hit   = (sfr_addr == `ADC_MODE_ADDR);
  assign conv_end  = (state_q != ST_IDLE) && (cnt_q == 8'h01);
  assign block_end = conv_end && (state_q == ST_BLOCK) && block_last_conv;
  assign hw_start  = (timer_two_trigger_enable & timer_two_overflow) | trig.pin_start;
  assign sw_start  = reg_q[`BIT_ONE_SHOT] | reg_q[`BIT_REPEAT];
  // One OR of all sources: coincident requests give a single start.
  assign any_start = (state_q == ST_IDLE) && (hw_start | sw_start | reg_q[`BIT_BLOCK]);
  // Block relaunches count as starts, so the channel is taken once per conversion and then held.
  assign next_start = any_start || (state_q == ST_BLOCK && conv_end && !block_last_conv);
  assign use_block  = (state_q == ST_IDLE) ? reg_q[`BIT_BLOCK] : (state_q == ST_BLOCK);

  always_comb begin
    reg_d = reg_q;
    if (sel_hit && sfr_wr) begin
      reg_d = sfr_wdata;
    end else if (sel_hit && bit_wr) begin
      reg_d[bit_sel] = bit_val;
    end
    if (irq_vector_ack) begin
      reg_d[`BIT_DONE] = 1'b0;
    end
    // Hardware set wins over a same-cycle clear.
    if (conv_end && (state_q == ST_CONV)) begin
      reg_d[`BIT_DONE]     = 1'b1;
      reg_d[`BIT_ONE_SHOT] = 1'b0;
    end
    if (block_end) begin
      reg_d[`BIT_DONE]  = 1'b1;
      reg_d[`BIT_BLOCK] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_q <= `ADC_MODE_RESET;
    end else begin
      reg_q <= reg_d;
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (any_start) begin
            state_q <= reg_q[`BIT_BLOCK] ? ST_BLOCK : ST_CONV;
            cnt_q   <= 8'(CONV_CYCLES);
          end
        end
        ST_CONV: begin
          cnt_q <= cnt_q - 8'h01;
          if (conv_end) begin
            // Repeat mode drops through idle for one cycle, then restarts.
            state_q <= ST_IDLE;
          end
        end
        ST_BLOCK: begin
          if (conv_end && !block_last_conv) begin
            cnt_q <= 8'(CONV_CYCLES);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
          if (block_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
      conv_chan  <= 4'h0;
      conv_src   <= SRC_ANALOG;
    end else begin
      conv_start <= next_start;
      if (next_start) begin
        conv_chan <= use_block ? block_chan : reg_q[`CHAN_HI:`CHAN_LO];
        if (use_block ? block_chan[`CHAN_HI] : reg_q[`CHAN_HI]) begin
          case (use_block ? block_chan : reg_q[`CHAN_HI:`CHAN_LO])
            `CHAN_TEMP: conv_src <= SRC_TEMP;
            `CHAN_DAC0: conv_src <= SRC_DAC;
            `CHAN_DAC1: conv_src <= SRC_DAC;
            default:    conv_src <= SRC_GROUND;
          endcase
        end else begin
          conv_src <= SRC_ANALOG;
        end
      end
    end
  end

  // Strobe held low only while block mode is armed and not yet running.
  assign ale_out        = (reg_q[`BIT_BLOCK] && state_q != ST_BLOCK) ? 1'b0 : core_ale;
  assign conv_busy      = (state_q != ST_IDLE);
  assign conv_done_flag = reg_q[`BIT_DONE];
  assign sfr_rdata      = sel_hit ? reg_q : 8'h00;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  one_shot_done_a: assert property (conv_end && state_q == ST_CONV |=> conv_done_flag)
    else $error("done flag not set after conversion");
  block_done_a: assert property (block_end |=> conv_done_flag && !reg_q[`BIT_BLOCK])
    else $error("block end did not update flags");
  vector_clear_a: assert property (irq_vector_ack && !conv_end |=> !conv_done_flag)
    else $error("done flag not cleared on vector");
  one_shot_clear_a: assert property (conv_end && state_q == ST_CONV && !(sel_hit && (sfr_wr || bit_wr))
    |=> !reg_q[`BIT_ONE_SHOT])
    else $error("one-shot bit not cleared");
  strobe_gate_a: assert property (reg_q[`BIT_BLOCK] && state_q != ST_BLOCK |-> !ale_out)
    else $error("strobe not stopped");
  repeat_restart_a: assert property (conv_end && state_q == ST_CONV && reg_d[`BIT_REPEAT]
    |=> ##[0:1] conv_busy)
    else $error("repeat mode did not restart");
  chan_pick_a: assert property (any_start && !reg_q[`BIT_BLOCK] |=> conv_chan == $past(reg_q[`CHAN_HI:`CHAN_LO]))
    else $error("wrong channel latched");
  block_chan_a: assert property (any_start && reg_q[`BIT_BLOCK] |=> conv_chan == $past(block_chan))
    else $error("block channel not used");
  timer_start_a: assert property (state_q == ST_IDLE && timer_two_trigger_enable && timer_two_overflow
    |=> conv_start && conv_busy)
    else $error("timer trigger missed");
  read_map_a: assert property (sel_hit |-> sfr_rdata == reg_q)
    else $error("register readback wrong");
  // Starts land one edge after the request, so most checks look one edge ahead.
  pin_start_a: assert property (trig.pin_start && state_q == ST_IDLE |=> conv_start && conv_busy)
    else $error("pin trigger missed");
  block_relaunch_a: assert property (state_q == ST_BLOCK && conv_end && !block_last_conv |=> conv_start && conv_chan == $past(block_chan))
    else $error("block relaunch wrong");
  chan_hold_a: assert property (!next_start |=> $stable(conv_chan))
    else $error("channel changed without a start");
  strobe_pass_a: assert property (!(reg_q[`BIT_BLOCK] && state_q != ST_BLOCK) |-> ale_out == core_ale)
    else $error("strobe not passed through");
  busy_refuse_a: assert property (state_q == ST_CONV |=> !conv_start)
    else $error("start accepted while busy");
  done_hold_a: assert property (conv_done_flag && !irq_vector_ack && !(sel_hit && (sfr_wr || bit_wr)) |=> conv_done_flag)
    else $error("done flag lost");
  analog_map_a: assert property (next_start && !use_block && !reg_q[`CHAN_HI] |=> conv_src == SRC_ANALOG)
    else $error("analog source not chosen");
  temp_map_a: assert property (next_start && !use_block && reg_q[`CHAN_HI:`CHAN_LO] == `CHAN_TEMP |=> conv_src == SRC_TEMP)
    else $error("temperature source not chosen");

  single_cov: cover property (conv_end && state_q == ST_CONV);
  repeat_cov: cover property (conv_end && state_q == ST_CONV && reg_q[`BIT_REPEAT]);
  block_cov: cover property (block_end);
  pin_cov: cover property (trig.pin_start && state_q == ST_IDLE);
endmodule : adc_mode_control

//--- rtl/adc_mode_defines.svh
// Constants for the ADC conversion mode control register.
`ifndef ADC_MODE_DEFINES_SVH
`define ADC_MODE_DEFINES_SVH
// How it works
// - Done flag sets after single or block end
// - Flag clears on interrupt vector or software
// - Block enable bit self-clears at block end
// - Address strobe stops while block enable waits
// - Repeat bit restarts conversion after each one
// - One-shot bit runs one conversion, then clears
// - Block mode takes channel from memory sequence
// - Register at D8H, resets 00H, bit addressable
// - Codes map inputs, temperature, DACs, ground
// - Timer two overflow triggers when enabled
// - Low pulse on start pin triggers when enabled
`define ADC_MODE_ADDR     8'hD8
`define ADC_MODE_RESET    8'h00
`define BIT_DONE          7
`define BIT_BLOCK         6
`define BIT_REPEAT        5
`define BIT_ONE_SHOT      4
`define CHAN_HI           3
`define CHAN_LO           0
`define CHAN_TEMP         4'h8
`define CHAN_DAC0         4'h9
`define CHAN_DAC1         4'hA
`define CHAN_AGND         4'hB
`define MIN_PULSE_NS      100
`define CLK_PERIOD_NS     8
`define MIN_PULSE_CYC     ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- rtl/adc_mode_pkg.sv
// Types for the ADC conversion mode control block.
package adc_mode_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_BLOCK = 2'b10
  } conv_state_t;
  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00,
    SRC_TEMP   = 2'b01,
    SRC_DAC    = 2'b10,
    SRC_GROUND = 2'b11
  } chan_src_t;
endpackage : adc_mode_pkg

//--- rtl/start_trig_if.sv
// Start trigger bundle between the pin filter and the control logic.
interface start_trig_if;
  logic pin_enable;
  logic pin_start;
  modport filt (input pin_enable, output pin_start);
  modport ctrl (output pin_enable, input pin_start);
endinterface : start_trig_if

//--- rtl/start_pin_filter.sv
// Synchroniser and falling-edge detector for the external start pin.
`include "adc_mode_defines.svh"
module start_pin_filter (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ext_conv_start_pin_n,
  start_trig_if.filt trig
);
  import adc_mode_pkg::*;
  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  // Delay of the start edge is two cycles; the start pulse is one cycle wide whatever the pin's low time.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= ext_conv_start_pin_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign trig.pin_start = trig.pin_enable & prev_q & ~sync2_q;
endmodule : start_pin_filter

//--- tb/sfr_core_model.sv
// Core-side model that issues byte and bit writes to the special function registers.
module sfr_core_model (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_wr,
  output logic            bit_wr,
  output logic      [2:0] bit_sel,
  output logic            bit_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bus cycles
  // ****************************************
  // Data lines carry the inverse of the last value between writes, so stale data never looks valid.
  initial begin
    sfr_addr  = 8'hD8;
    sfr_wdata = 8'h00;
    sfr_wr    = 1'b0;
    bit_wr    = 1'b0;
    bit_sel   = 3'h0;
    bit_val   = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    sfr_addr  <= 8'hD8;
    sfr_wdata <= ~d;
  endtask : wr
  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge clk);
    bit_sel <= s;
    bit_val <= v;
    bit_wr  <= 1'b1;
    @(posedge clk);
    bit_wr  <= 1'b0;
    bit_val <= ~v;
  endtask : bw
endmodule : sfr_core_model

//--- tb/tb.sv
// Self-checking bench for the conversion mode control register.
`include "adc_mode_defines.svh"
module tb import adc_mode_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 4;
  logic clk, sys_rst, sfr_wr, bit_wr, bit_val, irq_vector_ack, timer_two_trigger_enable, pin_trigger_enable;
  logic timer_two_overflow, ext_conv_start_pin_n, block_last_conv, core_ale, ale_out, conv_start, conv_busy;
  logic conv_done_flag;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0] block_chan, conv_chan;
  logic [2:0] bit_sel;
  chan_src_t  conv_src;
  int         n_mismatch = 0;
  int         num_checks = 0;
  sfr_core_model core (.clk, .sfr_addr, .sfr_wdata, .sfr_wr, .bit_wr, .bit_sel, .bit_val);
  adc_mode_control #(.CONV_CYCLES(CONV)) dut (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .bit_wr,
    .bit_sel, .bit_val, .sfr_rdata, .irq_vector_ack, .timer_two_trigger_enable, .pin_trigger_enable,
    .timer_two_overflow, .ext_conv_start_pin_n, .block_last_conv, .block_chan, .core_ale, .ale_out,
    .conv_start, .conv_chan, .conv_src, .conv_busy, .conv_done_flag);
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) core_ale <= ~core_ale;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Bounded wait for a start pulse or for the done flag.
  task automatic wait_hi(input bit done);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if ((done ? conv_done_flag : conv_start) === 1'b1) return;
    end
    chk("wait bound", 8'h01, 8'h00);
    results();
  endtask : wait_hi
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("reset value", 8'h00, sfr_rdata);
    core.wr(8'hD0, 8'h10);
    repeat (CONV + 3) @(posedge clk);
    #1;
    chk("unmapped write", 8'h00, {sfr_rdata[7:1], conv_busy});
  endtask : t_reset
  task automatic t_codes();
    logic [3:0] code [6] = '{4'h0, 4'h7, `CHAN_TEMP, `CHAN_DAC0, `CHAN_DAC1, `CHAN_AGND};
    chan_src_t  src [6]  = '{SRC_ANALOG, SRC_ANALOG, SRC_TEMP, SRC_DAC, SRC_DAC, SRC_GROUND};
    for (int i = 0; i < 6; i++) begin
      core.wr(8'hD8, {4'h1, code[i]});
      wait_hi(1'b0);
      chk("conv chan", {4'h0, code[i]}, {4'h0, conv_chan});
      chk("conv src", {6'h0, src[i]}, {6'h0, conv_src});
      wait_hi(1'b1);
      chk("after one shot", {4'h8, code[i]}, sfr_rdata);
      if (i % 2 == 0) begin
        @(posedge clk) irq_vector_ack <= 1'b1;
        @(posedge clk) irq_vector_ack <= 1'b0;
      end else begin
        core.bw(3'h7, 1'b0);
      end
      @(posedge clk);
      #1;
      chk("flag cleared", {4'h0, code[i]}, sfr_rdata);
    end
  endtask : t_codes
  task automatic t_repeat();
    core.wr(8'hD8, 8'h21);
    wait_hi(1'b0);
    wait_hi(1'b0);
    chk("repeat chan", 8'h01, {4'h0, conv_chan});
    core.wr(8'hD8, 8'h00);
    repeat (CONV + 4) @(posedge clk);
    core.wr(8'hD8, 8'h00);
    #1;
    chk("repeat stopped", 8'h00, {sfr_rdata[7:1], conv_busy});
  endtask : t_repeat
  task automatic t_block();
    @(posedge clk) block_chan <= 4'h5;
    core.wr(8'hD8, 8'h02);
    core.bw(3'h6, 1'b1);
    #1;
    chk("ale held", 8'h00, {7'h0, ale_out});
    wait_hi(1'b0);
    chk("block chan", 8'h05, {4'h0, conv_chan});
    chk("ale running", {7'h0, core_ale}, {7'h0, ale_out});
    @(posedge clk) block_chan <= 4'h9;
    wait_hi(1'b0);
    chk("block chan next", 8'h09, {4'h0, conv_chan});
    chk("block src next", {6'h0, SRC_DAC}, {6'h0, conv_src});
    @(posedge clk) block_last_conv <= 1'b1;
    wait_hi(1'b1);
    chk("block end", 8'h82, sfr_rdata);
    chk("ale after", {7'h0, core_ale}, {7'h0, ale_out});
    @(posedge clk) block_last_conv <= 1'b0;
    core.wr(8'hD8, 8'h00);
  endtask : t_block
  task automatic t_triggers();
    int n = 0;
    @(posedge clk) timer_two_trigger_enable <= 1'b1;
    timer_two_overflow <= 1'b1;
    @(posedge clk) timer_two_overflow <= 1'b0;
    #1;
    chk("timer start", 8'h01, {7'h0, conv_start});
    wait_hi(1'b1);
    core.wr(8'hD8, 8'h00);
    @(posedge clk) pin_trigger_enable <= 1'b1;
    ext_conv_start_pin_n <= 1'b0;
    wait_hi(1'b0);
    repeat (`MIN_PULSE_CYC) @(posedge clk);
    ext_conv_start_pin_n <= 1'b1;
    wait_hi(1'b1);
    core.wr(8'hD8, 8'h00);
    fork
      core.wr(8'hD8, 8'h10);
      begin
        @(posedge clk) timer_two_overflow <= 1'b1;
        @(posedge clk) timer_two_overflow <= 1'b0;
      end
    join
    #1;
    n += int'(conv_start);
    repeat (3 * CONV + 6) begin
      @(posedge clk);
      #1;
      n += int'(conv_start);
    end
    chk("merged starts", 8'h01, 8'(n));
    chk("merged reg", 8'h80, sfr_rdata);
  endtask : t_triggers
  initial begin
    {sys_rst, irq_vector_ack, timer_two_trigger_enable, pin_trigger_enable} = 4'hF;
    {irq_vector_ack, timer_two_trigger_enable, pin_trigger_enable, timer_two_overflow} = 4'h0;
    {block_last_conv, core_ale, ext_conv_start_pin_n, block_chan} = 7'h14;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_codes();
    t_repeat();
    t_block();
    t_triggers();
    results();
  end
endmodule : tb
